// >>> bench/aio_bridge_model.sv
// Bridge-side model: issues single longword accesses on the local bus.
// Assumes the bank answers with a one-cycle ack after the strobe edge.
`timescale 1ns/1ns
module aio_bridge_model (
  input  wire logic        i_clk_sys,
  output logic             o_bus_rd,
  output logic             o_bus_wr,
  output logic [5:0]       o_bus_addr,
  output logic [31:0]      o_bus_wdata,
  input  wire logic [31:0] i_bus_rdata,
  input  wire logic        i_bus_ack,
  output logic [7:0]       o_missed_acks
);
  initial
  begin
    o_bus_rd      = 1'b0;
    o_bus_wr      = 1'b0;
    o_bus_addr    = 6'h3f;
    o_bus_wdata   = 32'h0000_0000;
    o_missed_acks = 8'h00;
  end

  // ==========================================================
  // Access task
  // Always a whole longword; no byte lanes exist on this port
  task automatic access(input logic wr, input logic [5:0] addr, input logic [31:0] data,
                        output logic [31:0] rdata);
    int n;
    @(posedge i_clk_sys);
    o_bus_rd    <= ~wr;
    o_bus_wr    <= wr;
    o_bus_addr  <= addr;
    o_bus_wdata <= data;
    @(posedge i_clk_sys);
    o_bus_rd <= 1'b0;
    o_bus_wr <= 1'b0;
    n = 0;
    do
    begin
      @(posedge i_clk_sys);
      n++;
    end
    while (i_bus_ack !== 1'b1 && n < 8);
    if (n >= 8)
      o_missed_acks <= o_missed_acks + 8'h01;
    rdata = i_bus_rdata;
    // Released lines turned round so a stale value is never mistaken for a held one
    o_bus_addr  <= ~addr;
    o_bus_wdata <= ~data;
  endtask
endmodule

// >>> bench/tb_aio_register_map_and_sync.sv
// Self-checking bench for the register bank and sync lines.
// Assumes the bridge model drives the bus; bench drives streams, events, sync pins.
`timescale 1ns/1ns
module tb_aio_register_map_and_sync;
  import aio_regs_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        bus_rd, bus_wr, bus_ack, ain_ready, aout_valid, irq;
  logic [5:0]  bus_addr;
  logic [31:0] bus_wdata, bus_rdata, aout_sample, board_control, first_rate, second_rate, scan_setup;
  logic [31:0] ain_sample = 32'h0000_0000;
  logic        ain_valid = 1'b0;
  logic        aout_ready = 1'b0;
  logic [7:0]  irq_events = 8'h00;
  logic [7:0]  missed_acks;
  logic        sync_in_se_n = 1'b1;
  logic        sync_in_p = 1'b1;
  logic        sync_in_n = 1'b0;
  logic        sync_event = 1'b0;
  logic        sync_out_se_n, sync_out_p, sync_out_n, pace_ai, pace_ao;
  logic [3:0]  discrete_out;
  int          failures = 0;
  int          comparisons = 0;

  always #4 clk_sys = ~clk_sys;

  aio_register_map_and_sync DUT (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_bus_rd(bus_rd), .i_bus_wr(bus_wr),
    .i_bus_addr(bus_addr), .i_bus_wdata(bus_wdata), .o_bus_rdata(bus_rdata), .o_bus_ack(bus_ack),
    .i_ain_sample(ain_sample), .i_ain_valid(ain_valid), .o_ain_ready(ain_ready), .o_aout_sample(aout_sample),
    .o_aout_valid(aout_valid), .i_aout_ready(aout_ready), .i_irq_events(irq_events), .o_irq(irq),
    .i_sync_in_single_ended_n(sync_in_se_n), .i_sync_in_pair_p(sync_in_p), .i_sync_in_pair_n(sync_in_n),
    .i_sync_event(sync_event), .o_sync_out_single_ended_n(sync_out_se_n), .o_sync_out_pair_p(sync_out_p),
    .o_sync_out_pair_n(sync_out_n), .o_pace_ai(pace_ai), .o_pace_ao(pace_ao), .o_board_control(board_control),
    .o_first_rate_gen(first_rate), .o_second_rate_gen(second_rate), .o_scan_sync_setup(scan_setup),
    .o_discrete_out(discrete_out));

  aio_bridge_model BRG (.i_clk_sys(clk_sys), .o_bus_rd(bus_rd), .o_bus_wr(bus_wr), .o_bus_addr(bus_addr),
    .o_bus_wdata(bus_wdata), .i_bus_rdata(bus_rdata), .i_bus_ack(bus_ack), .o_missed_acks(missed_acks));

  // ==========================================================
  // Shared helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    BRG.access(1'b1, a, d, q);
  endtask

  task automatic rchk(input string what, input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    BRG.access(1'b0, a, 32'h0000_0000, q);
    check(what, q, exp);
  endtask

  // Sync path is two synchroniser flops plus an output flop
  task automatic settle();
    repeat (6) @(posedge clk_sys);
  endtask

  // ==========================================================
  // Scenarios
  task automatic reset_values();
    rchk("board_control", OFS_BOARD_CONTROL, RST_BOARD_CONTROL);
    rchk("interrupt_control", OFS_INTERRUPT_CONTROL, RST_INTERRUPT_CONTROL);
    rchk("input_buffer_control", OFS_INPUT_BUFFER_CTRL, RST_BUFFER_CONTROL);
    rchk("first_rate", OFS_FIRST_RATE_GEN, RST_FIRST_RATE_GEN);
    rchk("second_rate", OFS_SECOND_RATE_GEN, RST_SECOND_RATE_GEN);
    rchk("output_buffer_control", OFS_OUTPUT_BUFFER_CTRL, RST_BUFFER_CONTROL);
    rchk("scan_sync_setup", OFS_SCAN_SYNC_SETUP, RST_SCAN_SYNC_SETUP);
    rchk("discrete_output", OFS_DISCRETE_OUTPUT, RST_DISCRETE_OUTPUT);
    for (int a = 6'h30; a <= 6'h3c; a += 4)
      rchk("unused_space", a[5:0], ZERO_WORD);
    check("board_control copy", board_control, RST_BOARD_CONTROL);
    check("scan_sync_setup copy", scan_setup, RST_SCAN_SYNC_SETUP);
  endtask

  task automatic write_back();
    wr(OFS_BOARD_CONTROL, 32'hffff_a7af);
    rchk("board_control", OFS_BOARD_CONTROL, (32'hffff_a7af & BCR_WRITE_MASK) | 32'h0000_4000);
    wr(OFS_FIRST_RATE_GEN, 32'h5a5a_a5a5);
    wr(OFS_SECOND_RATE_GEN, 32'h0f0f_f0f0);
    wr(OFS_DISCRETE_OUTPUT, 32'h0000_000a);
    wr(OFS_INPUT_BUFFER_CTRL, 32'h0000_1234);
    // Writes to read-only and unused places must leave everything alone
    wr(OFS_LOGIC_VERSION, 32'hdead_beef);
    wr(OFS_CALIBRATION_VALUES, 32'hdead_beef);
    wr(6'h34, 32'hdead_beef);
    rchk("first_rate", OFS_FIRST_RATE_GEN, 32'h5a5a_a5a5);
    rchk("second_rate", OFS_SECOND_RATE_GEN, 32'h0f0f_f0f0);
    rchk("discrete_output", OFS_DISCRETE_OUTPUT, 32'h0000_000a);
    rchk("input_buffer_control", OFS_INPUT_BUFFER_CTRL, 32'h0000_1234);
    rchk("unused_space", 6'h34, ZERO_WORD);
    check("first_rate copy", first_rate, 32'h5a5a_a5a5);
    check("second_rate copy", second_rate, 32'h0f0f_f0f0);
    check("discrete_out", {28'h0, discrete_out}, 32'h0000_000a);
  endtask

  task automatic input_stream();
    int n;
    n = 0;
    @(posedge clk_sys);
    ain_sample <= 32'h0000_0100;
    ain_valid  <= 1'b1;
    repeat (7)
    begin
      @(posedge clk_sys);
      if (ain_ready === 1'b1)
      begin
        n++;
        ain_sample <= 32'h0000_0100 + n;
      end
    end
    ain_valid <= 1'b0;
    check("samples taken", n, 32'd4);
    check("ain_ready when full", {31'h0, ain_ready}, 32'h0);
    wr(OFS_INPUT_SAMPLE_BUFFER, 32'hdead_beef);
    for (int k = 0; k < 4; k++)
      rchk("input sample", OFS_INPUT_SAMPLE_BUFFER, 32'h0000_0100 + k);
    rchk("input sample empty", OFS_INPUT_SAMPLE_BUFFER, ZERO_WORD);
  endtask

  task automatic output_stream();
    int n;
    n = 0;
    for (int k = 0; k < 5; k++)
      wr(OFS_OUTPUT_SAMPLE_BUF, 32'h0000_0a00 + k);
    rchk("output buffer read", OFS_OUTPUT_SAMPLE_BUF, ZERO_WORD);
    check("aout_valid", {31'h0, aout_valid}, 32'h1);
    aout_ready <= 1'b1;
    repeat (8)
    begin
      @(posedge clk_sys);
      if (aout_valid === 1'b1)
      begin
        check("output sample", aout_sample, 32'h0000_0a00 + n);
        n++;
      end
    end
    check("output samples", n, 32'd4);
    aout_ready <= 1'b0;
  endtask

  task automatic sync_lines(input logic exp_n, input string what);
    settle();
    check(what, {29'h0, sync_out_se_n, sync_out_p, sync_out_n}, {29'h0, exp_n, exp_n, ~exp_n});
  endtask

  task automatic sync_chain();
    sync_lines(1'b1, "sync idle");
    sync_in_se_n <= 1'b0;
    sync_lines(1'b0, "sync from single-ended");
    for (int m = 0; m < 4; m++)
    begin
      wr(OFS_SCAN_SYNC_SETUP, RST_SCAN_SYNC_SETUP | (m << SYNC_IN_PACE_AI_BIT));
      settle();
      check("pace", {30'h0, pace_ao, pace_ai}, m);
    end
    check("scan_sync_setup copy", scan_setup, RST_SCAN_SYNC_SETUP | 32'h0000_3000);
    sync_in_se_n <= 1'b1;
    sync_lines(1'b1, "sync released");
    sync_in_p <= 1'b0;
    sync_in_n <= 1'b1;
    sync_lines(1'b0, "sync from pair");
    check("pace from pair", {30'h0, pace_ao, pace_ai}, 32'h3);
    sync_in_p <= 1'b1;
    sync_in_n <= 1'b0;
    sync_event <= 1'b1;
    sync_lines(1'b0, "sync from local event");
    sync_event <= 1'b0;
    wr(OFS_BOARD_CONTROL, 32'h0000_0800);
    sync_lines(1'b0, "sync from control bit");
    wr(OFS_BOARD_CONTROL, RST_BOARD_CONTROL);
    sync_lines(1'b1, "sync off");
  endtask

  task automatic pulse_event(input logic [7:0] ev);
    @(posedge clk_sys);
    irq_events <= ev;
    @(posedge clk_sys);
    irq_events <= 8'h00;
    settle();
  endtask

  task automatic interrupt_path();
    pulse_event(8'h04);
    check("irq masked", {31'h0, irq}, 32'h0);
    // Flags clear where a one is written; enable bit kept
    wr(OFS_INTERRUPT_CONTROL, RST_INTERRUPT_CONTROL | 32'h0000_0400);
    pulse_event(8'h08);
    check("irq raised", {31'h0, irq}, 32'h1);
    rchk("interrupt flags", OFS_INTERRUPT_CONTROL, 32'h0000_0808);
    wr(OFS_INTERRUPT_CONTROL, RST_INTERRUPT_CONTROL | 32'h0000_0800);
    settle();
    check("irq cleared", {31'h0, irq}, 32'h0);
  endtask

  // ==========================================================
  // Verdict, main sequence, watchdog
  task automatic give_verdict();
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    reset_values();
    write_back();
    input_stream();
    output_stream();
    sync_chain();
    interrupt_path();
    check("missed acks", {24'h0, missed_acks}, 32'h0);
    give_verdict();
  end

  initial
  begin
    #200000;
    failures++;
    give_verdict();
  end
endmodule

// >>> src/aio_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/1ns
module aio_fifo
  import aio_regs_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
)(
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  output logic [WIDTH-1:0]      o_out_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wptr_ff;
  logic [AW-1:0]    rptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_in_ready  = (count_ff != DEPTH[AW:0]);
  assign o_out_valid = (count_ff != '0);
  assign o_out_data  = mem_ff[rptr_ff];

  always_ff @(posedge i_clk_sys)
  begin
    if (push)
      mem_ff[wptr_ff] <= i_in_data;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wptr_ff  <= '0;
      rptr_ff  <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (push)
        wptr_ff <= wptr_ff + 1'b1;
      if (pop)
        rptr_ff <= rptr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> src/aio_register_map_and_sync.sv
// Register bank and sync lines of the analog I/O board.
// Assumes the bridge issues single-cycle 32-bit accesses; sync pins are asynchronous.
`timescale 1ns/1ns
module aio_register_map_and_sync
  import aio_regs_pkg::*;
#(
  parameter int          FIFO_DEPTH   = 4,
  parameter logic [31:0] VERSION_WORD = 32'h0000_0001  // Value is arbitrary
)(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_bus_rd,
  input  wire logic        i_bus_wr,
  input  wire logic [5:0]  i_bus_addr,
  input  wire logic [31:0] i_bus_wdata,
  output logic [31:0]      o_bus_rdata,
  output logic             o_bus_ack,
  input  wire logic [31:0] i_ain_sample,
  input  wire logic        i_ain_valid,
  output logic             o_ain_ready,
  output logic [31:0]      o_aout_sample,
  output logic             o_aout_valid,
  input  wire logic        i_aout_ready,
  input  wire logic [7:0]  i_irq_events,
  output logic             o_irq,
  input  wire logic        i_sync_in_single_ended_n,
  input  wire logic        i_sync_in_pair_p,
  input  wire logic        i_sync_in_pair_n,
  input  wire logic        i_sync_event,
  output logic             o_sync_out_single_ended_n,
  output logic             o_sync_out_pair_p,
  output logic             o_sync_out_pair_n,
  output logic             o_pace_ai,
  output logic             o_pace_ao,
  output logic [31:0]      o_board_control,
  output logic [31:0]      o_first_rate_gen,
  output logic [31:0]      o_second_rate_gen,
  output logic [31:0]      o_scan_sync_setup,
  output logic [3:0]       o_discrete_out
);

  // ==========================================================
  // Bus request capture
  bus_req_type req;
  assign req = '{rd: i_bus_rd, wr: i_bus_wr, addr: {i_bus_addr[5:2], 2'b00}, wdata: i_bus_wdata};

  logic [31:0] board_control_ff;
  logic [31:0] interrupt_control_ff;
  logic [31:0] input_buffer_ctrl_ff;
  logic [31:0] output_buffer_ctrl_ff;
  logic [31:0] first_rate_gen_ff;
  logic [31:0] second_rate_gen_ff;
  logic [31:0] scan_sync_setup_ff;
  logic [31:0] discrete_output_ff;
  logic [31:0] nxt_rdata;

  // Low two address bits ignored: only longword accesses exist
  logic wr_hit;
  assign wr_hit = req.wr;

  // ==========================================================
  // Input path: samples flow through a FIFO, popped by reads of 0x08
  logic [31:0] ain_q_data;
  logic        ain_q_valid;
  logic        ain_pop;
  assign ain_pop = req.rd && (req.addr == OFS_INPUT_SAMPLE_BUFFER) && ain_q_valid;

  aio_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_ain_fifo
  (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (i_rst_n),
    .i_in_data   (i_ain_sample),
    .i_in_valid  (i_ain_valid),
    .o_in_ready  (o_ain_ready),
    .o_out_data  (ain_q_data),
    .o_out_valid (ain_q_valid),
    .i_out_ready (ain_pop)
  );

  // ==========================================================
  // Output path: writes of 0x18 push; a full FIFO drops the word
  logic aout_push;
  logic aout_in_ready;
  assign aout_push = wr_hit && (req.addr == OFS_OUTPUT_SAMPLE_BUF) && aout_in_ready;

  aio_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_aout_fifo
  (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (i_rst_n),
    .i_in_data   (req.wdata),
    .i_in_valid  (aout_push),
    .o_in_ready  (aout_in_ready),
    .o_out_data  (o_aout_sample),
    .o_out_valid (o_aout_valid),
    .i_out_ready (i_aout_ready)
  );

  // ==========================================================
  // Register writes
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      board_control_ff      <= RST_BOARD_CONTROL;
      first_rate_gen_ff     <= RST_FIRST_RATE_GEN;
      second_rate_gen_ff    <= RST_SECOND_RATE_GEN;
      input_buffer_ctrl_ff  <= RST_BUFFER_CONTROL;
      output_buffer_ctrl_ff <= RST_BUFFER_CONTROL;
      scan_sync_setup_ff    <= RST_SCAN_SYNC_SETUP;
      discrete_output_ff    <= RST_DISCRETE_OUTPUT;
    end
    else if (wr_hit)
    begin
      case (req.addr)
        OFS_BOARD_CONTROL:      board_control_ff <= (req.wdata & BCR_WRITE_MASK) |
                                                    (board_control_ff & ~BCR_WRITE_MASK);
        OFS_INPUT_BUFFER_CTRL:  input_buffer_ctrl_ff  <= req.wdata;
        OFS_FIRST_RATE_GEN:     first_rate_gen_ff     <= req.wdata;
        OFS_SECOND_RATE_GEN:    second_rate_gen_ff    <= req.wdata;
        OFS_OUTPUT_BUFFER_CTRL: output_buffer_ctrl_ff <= req.wdata;
        OFS_SCAN_SYNC_SETUP:    scan_sync_setup_ff    <= req.wdata;
        OFS_DISCRETE_OUTPUT:    discrete_output_ff    <= req.wdata;
        // Read-only and reserved space ignore writes; write-only buffer writes go to the output FIFO, not to a register
        default:                ;
      endcase
    end
  end

  // ==========================================================
  // Interrupt control: enables in low byte, sticky flags above
  logic [7:0] irq_flags;
  logic [7:0] irq_clr;
  assign irq_flags = interrupt_control_ff[IRQ_FLAG_LSB +: IRQ_EVENTS];
  assign irq_clr   = (wr_hit && req.addr == OFS_INTERRUPT_CONTROL) ?
                     ~req.wdata[IRQ_FLAG_LSB +: IRQ_EVENTS] : 8'hff;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      interrupt_control_ff <= RST_INTERRUPT_CONTROL;
    else
    begin
      // Flags clear by writing one; a new event in that cycle wins
      interrupt_control_ff[IRQ_FLAG_LSB +: IRQ_EVENTS] <= (irq_flags & irq_clr) | i_irq_events;
      if (wr_hit && req.addr == OFS_INTERRUPT_CONTROL)
        interrupt_control_ff[IRQ_EVENTS-1:0] <= req.wdata[IRQ_EVENTS-1:0];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_irq <= 1'b0;
    else
      o_irq <= |(irq_flags & interrupt_control_ff[IRQ_ENABLE_LSB +: IRQ_EVENTS]);
  end

  // ==========================================================
  // Read mux
  always_comb
  begin
    nxt_rdata = ZERO_WORD;
    case (req.addr)
      OFS_BOARD_CONTROL:       nxt_rdata = board_control_ff;
      OFS_INTERRUPT_CONTROL:   nxt_rdata = interrupt_control_ff;
      OFS_INPUT_SAMPLE_BUFFER: nxt_rdata = ain_q_valid ? ain_q_data : ZERO_WORD;
      OFS_INPUT_BUFFER_CTRL:   nxt_rdata = input_buffer_ctrl_ff;
      OFS_FIRST_RATE_GEN:      nxt_rdata = first_rate_gen_ff;
      OFS_SECOND_RATE_GEN:     nxt_rdata = second_rate_gen_ff;
      OFS_OUTPUT_SAMPLE_BUF:   nxt_rdata = ZERO_WORD;
      OFS_OUTPUT_BUFFER_CTRL:  nxt_rdata = output_buffer_ctrl_ff;
      OFS_SCAN_SYNC_SETUP:     nxt_rdata = scan_sync_setup_ff;
      OFS_DISCRETE_OUTPUT:     nxt_rdata = discrete_output_ff;
      OFS_LOGIC_VERSION:       nxt_rdata = VERSION_WORD;
      OFS_CALIBRATION_VALUES:  nxt_rdata = ZERO_WORD;
      default:                 nxt_rdata = ZERO_WORD;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_bus_rdata <= ZERO_WORD;
      o_bus_ack   <= 1'b0;
    end
    else
    begin
      o_bus_rdata <= req.rd ? nxt_rdata : ZERO_WORD;
      o_bus_ack   <= req.rd || req.wr;
    end
  end

  // ==========================================================
  // Sync inputs: two-stage synchronisers, then combine
  logic [1:0] se_sync_ff;
  logic [1:0] pp_sync_ff;
  logic [1:0] pn_sync_ff;
  logic       sync_in_active;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // Idle high means inactive
      se_sync_ff <= 2'b11;
      pp_sync_ff <= 2'b11;
      pn_sync_ff <= 2'b00;
    end
    else
    begin
      se_sync_ff <= {se_sync_ff[0], i_sync_in_single_ended_n};
      pp_sync_ff <= {pp_sync_ff[0], i_sync_in_pair_p};
      pn_sync_ff <= {pn_sync_ff[0], i_sync_in_pair_n};
    end
  end

  // Pair asserted when low side above high side, same sense as single-ended
  assign sync_in_active = !se_sync_ff[1] || (!pp_sync_ff[1] && pn_sync_ff[1]);

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pace_ai <= 1'b0;
      o_pace_ao <= 1'b0;
    end
    else
    begin
      o_pace_ai <= sync_in_active && scan_sync_setup_ff[SYNC_IN_PACE_AI_BIT];
      o_pace_ao <= sync_in_active && scan_sync_setup_ff[SYNC_IN_PACE_AO_BIT];
    end
  end

  // ==========================================================
  // Sync outputs: local event, software strobe, or chain the input onward
  logic sync_out_req;
  assign sync_out_req = i_sync_event || sync_in_active ||
                        board_control_ff[BCR_INPUT_SYNC_BIT] ||
                        board_control_ff[BCR_OUTPUT_SYNC_BIT];

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_sync_out_single_ended_n <= 1'b1;
      o_sync_out_pair_p         <= 1'b1;
      o_sync_out_pair_n         <= 1'b0;
    end
    else
    begin
      o_sync_out_single_ended_n <= !sync_out_req;
      o_sync_out_pair_p         <= !sync_out_req;
      o_sync_out_pair_n         <= sync_out_req;
    end
  end

  // ==========================================================
  // Register copies toward the board logic
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_board_control   <= RST_BOARD_CONTROL;
      o_first_rate_gen  <= RST_FIRST_RATE_GEN;
      o_second_rate_gen <= RST_SECOND_RATE_GEN;
      o_scan_sync_setup <= RST_SCAN_SYNC_SETUP;
      o_discrete_out    <= RST_DISCRETE_OUTPUT[3:0];
    end
    else
    begin
      o_board_control   <= board_control_ff;
      o_first_rate_gen  <= first_rate_gen_ff;
      o_second_rate_gen <= second_rate_gen_ff;
      o_scan_sync_setup <= scan_sync_setup_ff;
      o_discrete_out    <= discrete_output_ff[3:0];
    end
  end

  // ==========================================================
  // Checks
  property p_reserved_zero;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (req.rd && req.addr >= 6'h30) |=> (o_bus_rdata == ZERO_WORD);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved read not zero");

  property p_outbuf_read_zero;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (req.rd && req.addr == OFS_OUTPUT_SAMPLE_BUF) |=> (o_bus_rdata == ZERO_WORD) && o_bus_ack;
  endproperty
  a_outbuf_read_zero: assert property (p_outbuf_read_zero) else $error("output buffer read nonzero");

  property p_sync_out_low;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_sync_event |=> !o_sync_out_single_ended_n && o_sync_out_pair_n;
  endproperty
  a_sync_out_low: assert property (p_sync_out_low) else $error("sync out not asserted low");

  property p_sync_in_idle;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (se_sync_ff[1] && pp_sync_ff[1]) |=> !o_pace_ai && !o_pace_ao;
  endproperty
  a_sync_in_idle: assert property (p_sync_in_idle) else $error("idle sync in paced");

  property p_pair_matches;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_sync_out_pair_p == o_sync_out_single_ended_n) && (o_sync_out_pair_n != o_sync_out_pair_p);
  endproperty
  a_pair_matches: assert property (p_pair_matches) else $error("pair differs from single");

  property p_pace_select;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (sync_in_active && !scan_sync_setup_ff[SYNC_IN_PACE_AI_BIT]) |=> !o_pace_ai;
  endproperty
  a_pace_select: assert property (p_pace_select) else $error("input paced while deselected");

  property p_irq_masked;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      ((irq_flags & interrupt_control_ff[7:0]) == 8'h00) |=> !o_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq without enabled flag");

  property p_ro_write_ignored;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (req.wr && req.addr == OFS_LOGIC_VERSION) |=> $stable(scan_sync_setup_ff) && $stable(first_rate_gen_ff);
  endproperty
  a_ro_write_ignored: assert property (p_ro_write_ignored) else $error("read-only write had effect");

  property p_rate_write;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (req.wr && req.addr == OFS_FIRST_RATE_GEN) |=> (first_rate_gen_ff == $past(i_bus_wdata));
  endproperty
  a_rate_write: assert property (p_rate_write) else $error("rate register write lost");

  property p_ack_follows;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (req.rd || req.wr) |=> o_bus_ack;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("access not acknowledged");

  property p_inbuf_read;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (req.rd && req.addr == OFS_INPUT_SAMPLE_BUFFER && ain_q_valid) |=> (o_bus_rdata == $past(ain_q_data));
  endproperty
  a_inbuf_read: assert property (p_inbuf_read) else $error("input sample read wrong");

  property p_irq_raise;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      ((irq_flags & interrupt_control_ff[7:0]) != 8'h00) |=> o_irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("enabled flag gave no irq");

endmodule

// >>> src/aio_regs_pkg.sv
// Package for the analog I/O board register bank.
// Assumes one local clock; bus is the bridge's local 32-bit register port.
package aio_regs_pkg;

  // ==========================================================
  // Register offsets (byte addresses within 16-longword window)
  localparam logic [5:0] OFS_BOARD_CONTROL       = 6'h00;
  localparam logic [5:0] OFS_INTERRUPT_CONTROL   = 6'h04;
  localparam logic [5:0] OFS_INPUT_SAMPLE_BUFFER = 6'h08;
  localparam logic [5:0] OFS_INPUT_BUFFER_CTRL   = 6'h0c;
  localparam logic [5:0] OFS_FIRST_RATE_GEN      = 6'h10;
  localparam logic [5:0] OFS_SECOND_RATE_GEN     = 6'h14;
  localparam logic [5:0] OFS_OUTPUT_SAMPLE_BUF   = 6'h18;
  localparam logic [5:0] OFS_OUTPUT_BUFFER_CTRL  = 6'h1c;
  localparam logic [5:0] OFS_SCAN_SYNC_SETUP     = 6'h20;
  localparam logic [5:0] OFS_DISCRETE_OUTPUT     = 6'h24;
  localparam logic [5:0] OFS_LOGIC_VERSION       = 6'h28;
  localparam logic [5:0] OFS_CALIBRATION_VALUES  = 6'h2c;

  // ==========================================================
  // Reset values
  localparam logic [31:0] RST_BOARD_CONTROL     = 32'h0000_4060;
  localparam logic [31:0] RST_INTERRUPT_CONTROL = 32'h0000_0008;
  localparam logic [31:0] RST_BUFFER_CONTROL    = 32'h0000_7ffe;
  localparam logic [31:0] RST_FIRST_RATE_GEN    = 32'h0001_09c4;
  localparam logic [31:0] RST_SECOND_RATE_GEN   = 32'h0000_0064;
  localparam logic [31:0] RST_SCAN_SYNC_SETUP   = 32'h0000_02d1;
  localparam logic [31:0] RST_DISCRETE_OUTPUT   = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD             = 32'h0000_0000;

  // ==========================================================
  // Field positions
  localparam int BCR_INPUT_SYNC_BIT  = 12;
  localparam int BCR_OUTPUT_SYNC_BIT = 11;
  localparam int SYNC_IN_PACE_AI_BIT = 12;  // scan_sync_setup: sync in paces input
  localparam int SYNC_IN_PACE_AO_BIT = 13;  // scan_sync_setup: sync in paces output
  localparam int IRQ_ENABLE_LSB      = 0;   // interrupt_control enables [7:0]
  localparam int IRQ_FLAG_LSB        = 8;   // interrupt_control flags [15:8]
  localparam int IRQ_EVENTS          = 8;
  localparam logic [31:0] BCR_WRITE_MASK = 32'h0000_bfff;

  // ==========================================================
  // Carrier for one local bus access
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [5:0]  addr;
    logic [31:0] wdata;
  } bus_req_type;

endpackage
